// [logic/wdm_map.svh]
// Register addresses, reset values and timing counts of the program loop watchdog
`ifndef WDM_MAP_SVH
`define WDM_MAP_SVH

// Register addresses on the CPU data bus
`define WDM_MODE_ADDR 16'hFF48
`define WDM_RESTART_ADDR 16'hFF49

// Reset and read values
`define WDM_MODE_RESET 8'h67
`define WDM_RESTART_READ 8'h9A
`define WDM_RESTART_KEY 8'hAC

// Mode register field layout
`define WDM_FIXED_MSB 7
`define WDM_FIXED_LSB 5
`define WDM_FIXED_VAL 3'h3
`define WDM_CS_MSB 4
`define WDM_CS_LSB 3
`define WDM_IV_MSB 2
`define WDM_IV_LSB 0
`define WDM_CS_RESET 2'h0
`define WDM_IV_RESET 3'h7

// Overflow tap bases for the two clock sources
`define WDM_LS_TAP_BASE 5'h0B
`define WDM_SYS_TAP_BASE 5'h0D

// Post-STOP pause, time in ns and its count of mclk cycles
`define WDM_CLK_NS 10
`define WDM_PAUSE_NS 34000
`define WDM_PAUSE_CYC (`WDM_PAUSE_NS / `WDM_CLK_NS)

`endif

// [logic/wdm_pkg.sv]
// Types shared by the program loop watchdog
`default_nettype none
package wdm_pkg;

	// Counting phase around low-power states
	typedef enum logic [1:0] {
		WDM_RUN = 2'b00,
		WDM_FROZEN = 2'b01,
		WDM_SETTLE = 2'b10,
		WDM_PAUSE = 2'b11
	} wdm_phase_t;

	// Whole state of the watchdog
	typedef struct packed {
		logic [1:0] clk_sel;
		logic [2:0] interval;
		logic written;
		logic stopped;
		logic [20:0] cnt;
		wdm_phase_t phase;
		logic stop_seen;
		logic [11:0] pause_cnt;
		logic [2:0] ls_sync;
		logic rst_req;
		logic cause;
		logic [7:0] rdata;
	} wdm_state_t;

endpackage : wdm_pkg
`default_nettype wire

// [logic/wdm_watchdog.sv]
// Program loop watchdog: mode and restart registers, counter, misuse and overflow reset
//
// How it works
// - Mode register takes one write after reset
// - Mode register reads 0x67 after reset
// - Clock select: 00 slow, 01 system, 1x stop
// - Overflow after 2^(11+n) slow or 2^(13+n)
// - Reset leaves longest interval, slow clock source
// - Counting starts by itself at reset release
// - Second mode write raises internal reset
// - Stopped at first write suppresses misuse resets
// - Key 0xAC to restart clears counter
// - Non-key restart write raises internal reset
// - Bit access to restart raises internal reset
// - Restart register always reads 0x9A
// - Any mode write clears the counter
// - Non-stoppable option: slow clock, select ignored
// - Non-stoppable option counts through STOP
// - Counter overflow raises internal reset
// - Stoppable option freezes and holds in HALT/STOP
// - After STOP, settle (system clock on crystal only) then 34 us pause
// - Watchdog reset sets the reset cause flag
// - Option byte picks stoppable or non-stoppable mode
`include "wdm_map.svh"
`timescale 1ns/1ps
`default_nettype none
module wdm_watchdog (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic [15:0] bus_addr,
	input wire logic bus_wr,
	input wire logic bus_rd,
	input wire logic bus_bit_op,
	input wire logic [7:0] bus_wdata,
	output logic [7:0] bus_rdata,
	input wire logic low_speed_osc_clock,
	input wire logic option_nonstop,
	input wire logic halt_mode,
	input wire logic stop_mode,
	input wire logic crystal_osc,
	input wire logic osc_settled,
	input wire logic cause_clear,
	output logic watchdog_reset_req,
	output logic watchdog_reset_cause_flag
);

	// State after reset: longest interval on the slow clock, counting
	localparam wdm_pkg::wdm_state_t RESET_STATE = '{
		clk_sel: `WDM_CS_RESET,
		interval: `WDM_IV_RESET,
		written: 1'b0,
		stopped: 1'b0,
		cnt: 21'h000000,
		phase: wdm_pkg::WDM_RUN,
		stop_seen: 1'b0,
		pause_cnt: 12'h000,
		ls_sync: 3'h0,
		rst_req: 1'b0,
		cause: 1'b0,
		rdata: 8'h00
	};

	localparam logic [11:0] PAUSE_LAST = 12'(`WDM_PAUSE_CYC - 1);

	wdm_pkg::wdm_state_t q;
	wdm_pkg::wdm_state_t d;

	// Decodes one register address, used for reads and writes
	function automatic logic wdm_hit(input logic [15:0] addr, input logic [15:0] reg_addr);
		wdm_hit = (addr == reg_addr);
	endfunction : wdm_hit

	// Mode register as seen by software
	function automatic logic [7:0] wdm_mode_view(input logic [1:0] cs, input logic [2:0] iv);
		wdm_mode_view = {`WDM_FIXED_VAL, cs, iv};
	endfunction : wdm_mode_view

	logic ls_edge;
	logic sel_sys;
	logic sel_stop;
	logic tick;
	logic [4:0] tap;
	logic overflow;
	logic mode_wr;
	logic restart_wr;
	logic misuse;
	logic low_power;

	// Clock source decode and count tick
	always_comb begin
		ls_edge = q.ls_sync[1] & ~q.ls_sync[2];
		sel_stop = q.clk_sel[1];
		sel_sys = (q.clk_sel == 2'h1);
		tick = sel_sys ? 1'b1 : ls_edge;
		tap = sel_sys ? (`WDM_SYS_TAP_BASE + {2'h0, q.interval})
			: (`WDM_LS_TAP_BASE + {2'h0, q.interval});
		overflow = q.cnt[tap] & ~sel_stop;
		low_power = halt_mode | stop_mode;
	end

	// Bus access decode and misuse detection
	always_comb begin
		mode_wr = bus_wr & wdm_hit(bus_addr, `WDM_MODE_ADDR);
		restart_wr = bus_wr & wdm_hit(bus_addr, `WDM_RESTART_ADDR);
		misuse = 1'b0;
		if (!q.stopped) begin
			if (mode_wr && q.written) begin
				misuse = 1'b1;
			end
			if (restart_wr && bus_bit_op) begin
				misuse = 1'b1;
			end
			if (restart_wr && (bus_wdata != `WDM_RESTART_KEY)) begin
				misuse = 1'b1;
			end
		end
	end

	// Next state
	always_comb begin
		d = q;
		d.rst_req = 1'b0;
		d.ls_sync = {q.ls_sync[1:0], low_speed_osc_clock};

		// Low-power phase tracking, only in the stoppable option
		if (option_nonstop) begin
			d.phase = wdm_pkg::WDM_RUN;
			d.stop_seen = 1'b0;
		end else begin
			case (q.phase)
				wdm_pkg::WDM_RUN: begin
					if (low_power) begin
						d.phase = wdm_pkg::WDM_FROZEN;
						d.stop_seen = stop_mode;
					end
				end
				wdm_pkg::WDM_FROZEN: begin
					if (stop_mode) begin
						d.stop_seen = 1'b1;
					end
					if (!low_power) begin
						d.pause_cnt = 12'h000;
						if (!q.stop_seen) begin
							d.phase = wdm_pkg::WDM_RUN;
						end else if (sel_sys && crystal_osc) begin
							d.phase = wdm_pkg::WDM_SETTLE;
						end else begin
							d.phase = wdm_pkg::WDM_PAUSE;
						end
					end
				end
				wdm_pkg::WDM_SETTLE: begin
					if (osc_settled) begin
						d.phase = wdm_pkg::WDM_PAUSE;
					end
				end
				wdm_pkg::WDM_PAUSE: begin
					if (q.pause_cnt == PAUSE_LAST) begin
						d.phase = wdm_pkg::WDM_RUN;
					end else begin
						d.pause_cnt = q.pause_cnt + 12'h001;
					end
				end
				default: begin
					d.phase = wdm_pkg::WDM_RUN;
				end
			endcase
		end

		// Counting; frozen phases hold the value
		if (q.phase == wdm_pkg::WDM_RUN && !sel_stop && tick) begin
			d.cnt = q.cnt + 21'h000001;
		end

		// Mode register write: each clears the counter, first one only loads the fields
		if (mode_wr) begin
			d.cnt = 21'h000000;
			if (!q.written) begin
				d.written = 1'b1;
				d.interval = bus_wdata[`WDM_IV_MSB:`WDM_IV_LSB];
				if (option_nonstop) begin
					d.clk_sel = `WDM_CS_RESET;
				end else begin
					d.clk_sel = bus_wdata[`WDM_CS_MSB:`WDM_CS_LSB];
					d.stopped = bus_wdata[`WDM_CS_MSB];
				end
			end
		end

		// Restart key clears the counter
		if (restart_wr && !bus_bit_op && bus_wdata == `WDM_RESTART_KEY) begin
			d.cnt = 21'h000000;
		end

		// Register reads, captured for one cycle later
		if (bus_rd) begin
			if (wdm_hit(bus_addr, `WDM_MODE_ADDR)) begin
				d.rdata = wdm_mode_view(q.clk_sel, q.interval);
			end else if (wdm_hit(bus_addr, `WDM_RESTART_ADDR)) begin
				d.rdata = `WDM_RESTART_READ;
			end else begin
				d.rdata = 8'h00;
			end
		end

		// Cause flag: a new watchdog reset wins over a clear
		d.cause = (q.cause & ~cause_clear) | overflow | misuse;

		// Internal reset returns the block to its reset state
		if (overflow || misuse) begin
			d = RESET_STATE;
			d.ls_sync = {q.ls_sync[1:0], low_speed_osc_clock};
			d.cause = 1'b1;
			d.rst_req = 1'b1;
		end
	end

	// State register
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			q <= RESET_STATE;
		end else begin
			q <= d;
		end
	end

	// Outputs straight from the state register
	assign bus_rdata = q.rdata;
	assign watchdog_reset_req = q.rst_req;
	assign watchdog_reset_cause_flag = q.cause;

endmodule : wdm_watchdog
`default_nettype wire

// [tb/wdm_watchdog_chk.sv]
// Port checks of the program loop watchdog
`include "wdm_map.svh"
`timescale 1ns/1ps
`default_nettype none
module wdm_watchdog_chk (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic [15:0] bus_addr,
	input wire logic bus_wr,
	input wire logic bus_rd,
	input wire logic bus_bit_op,
	input wire logic [7:0] bus_wdata,
	input wire logic [7:0] bus_rdata,
	input wire logic option_nonstop,
	input wire logic cause_clear,
	input wire logic watchdog_reset_req,
	input wire logic watchdog_reset_cause_flag
);
	logic wr_q;
	logic stp_q;
	default clocking @(posedge mclk); endclocking
	default disable iff (!reset_n);
	sequence s_req;
		##[1:2] watchdog_reset_req;
	endsequence
	// Tracks the first mode write and whether it stopped counting
	always_ff @(posedge mclk) begin
		if (!reset_n || watchdog_reset_req) begin
			wr_q <= 1'b0;
			stp_q <= 1'b0;
		end else if (bus_wr && bus_addr == `WDM_MODE_ADDR && !wr_q) begin
			wr_q <= 1'b1;
			stp_q <= bus_wdata[4] && !option_nonstop;
		end
	end
	a_bad_key: assert property (bus_wr && bus_addr == `WDM_RESTART_ADDR && !stp_q &&
		(bus_wdata != `WDM_RESTART_KEY || bus_bit_op) |-> s_req) else $error("restart misuse left no reset");
	a_mode_twice: assert property (bus_wr && bus_addr == `WDM_MODE_ADDR && wr_q && !stp_q |-> s_req)
		else $error("second mode write left no reset");
	a_stop_quiet: assert property (stp_q && bus_wr |=> !watchdog_reset_req [*2])
		else $error("reset while stopped");
	a_req_pulse: assert property (watchdog_reset_req |=> !watchdog_reset_req)
		else $error("reset request too long");
	a_cause_set: assert property (watchdog_reset_req |-> ##[0:1] watchdog_reset_cause_flag)
		else $error("cause flag not set");
	a_cause_hold: assert property (watchdog_reset_cause_flag && !cause_clear |=> watchdog_reset_cause_flag)
		else $error("cause flag lost");
	a_key_read: assert property (bus_rd && bus_addr == `WDM_RESTART_ADDR |=> bus_rdata == `WDM_RESTART_READ)
		else $error("restart read wrong");
	a_mode_fixed: assert property (bus_rd && bus_addr == `WDM_MODE_ADDR |=> bus_rdata[7:5] == 3'h3)
		else $error("mode fixed bits wrong");
	a_nonstop_sel: assert property (option_nonstop && bus_rd && bus_addr == `WDM_MODE_ADDR |=>
		bus_rdata[4:3] == 2'h0) else $error("clock select not forced");
endmodule : wdm_watchdog_chk
bind wdm_watchdog wdm_watchdog_chk u_chk (.mclk(mclk), .reset_n(reset_n), .bus_addr(bus_addr), .bus_wr(bus_wr),
	.bus_rd(bus_rd), .bus_bit_op(bus_bit_op), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
	.option_nonstop(option_nonstop), .cause_clear(cause_clear), .watchdog_reset_req(watchdog_reset_req),
	.watchdog_reset_cause_flag(watchdog_reset_cause_flag));
`default_nettype wire

// [tb/wdm_watchdog_bench.sv]
// Self-checking bench of the program loop watchdog
`include "wdm_map.svh"
`timescale 1ns/1ps
`default_nettype none
module wdm_watchdog_bench;
	logic mclk = 0, reset_n = 0, wr = 0, rd = 0, bop = 0, osc = 0, nst = 0, hlt = 0, clr = 0;
	logic stp = 0, xtl = 1, stl = 1;
	logic [15:0] adr = 16'h0000;
	logic [7:0] wd = 8'h00, rdat, rv;
	logic req, flag;
	int bad_count = 0, n_checks = 0, seed = 73, nreq = 0, h;
	wdm_watchdog DUT (.mclk(mclk), .reset_n(reset_n), .bus_addr(adr), .bus_wr(wr), .bus_rd(rd), .bus_bit_op(bop),
		.bus_wdata(wd), .bus_rdata(rdat), .low_speed_osc_clock(osc), .option_nonstop(nst), .halt_mode(hlt),
		.stop_mode(stp), .crystal_osc(xtl), .osc_settled(stl), .cause_clear(clr), .watchdog_reset_req(req),
		.watchdog_reset_cause_flag(flag));
	// Clocks: system every 10 ns, slow oscillator rising edge every 8 cycles
	initial forever #5 mclk = ~mclk;
	initial forever #40 osc = ~osc;
	always @(posedge mclk) if (req === 1'b1) nreq++;
	task conclude;
		if (bad_count == 0 && n_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : conclude
	task chk(input logic [31:0] s, input logic [31:0] e, input string nm);
		n_checks++;
		if (s !== e) begin
			bad_count++;
			$display("wrong value %s expected %0h seen %0h", nm, e, s);
		end
	endtask : chk
	task acc(input logic w, input logic [15:0] a, input logic [7:0] d, input logic b);
		@(negedge mclk);
		wr = w;
		rd = !w;
		adr = a;
		wd = d;
		bop = b;
		@(negedge mclk);
		wr = 0;
		rd = 0;
		bop = 0;
		@(negedge mclk);
	endtask : acc
	task mis(input logic [15:0] a, input logic [7:0] d, input logic b, input int e);
		int r0;
		r0 = nreq;
		acc(1, a, d, b);
		repeat (2) @(negedge mclk);
		chk(nreq - r0, e, "reset pulses");
	endtask : mis
	function int ovf(input logic [7:0] m);
		return m[3] ? (1 << (13 + m[2:0])) : 8 * (1 << (11 + m[2:0]));
	endfunction : ovf
	// Counts cycles to the overflow reset, halting (or stopping, then settling 200 cycles) for hh cycles midway
	task tov(input int hh, input int e, input logic s);
		int n, r0;
		n = 0;
		r0 = nreq;
		while (nreq == r0 && n < e + e / 128 + 40) begin
			@(negedge mclk);
			n++;
			hlt = !s && (n > 1000 && n <= 1000 + hh);
			stp = s && (n > 1000 && n <= 1000 + hh);
			stl = (n > 1200 + hh);
		end
		hlt = 0;
		stp = 0;
		stl = 1;
		chk(n > e - e / 128 - 40 && n < e + e / 128 + 40, 1, "overflow time");
	endtask : tov
	task rd_chk(input logic [15:0] a, input logic [7:0] e);
		acc(0, a, 8'h00, 0);
		chk(rdat, e, "read data");
	endtask : rd_chk
	initial begin
		repeat (4) @(negedge mclk);
		reset_n = 1;
		rd_chk(`WDM_MODE_ADDR, 8'h67);
		rd_chk(`WDM_RESTART_ADDR, 8'h9A);
		rd_chk(16'hFF4A, 8'h00);
		mis(`WDM_RESTART_ADDR, 8'hAC, 0, 0);
		rv = $random(seed);
		if (rv == 8'hAC) rv = 8'h00;
		mis(`WDM_RESTART_ADDR, rv, 0, 1);
		chk(flag, 1, "cause flag");
		@(negedge mclk) clr = 1;
		@(negedge mclk) clr = 0;
		chk(flag, 0, "cause flag");
		mis(`WDM_RESTART_ADDR, 8'hAC, 1, 1);
		mis(`WDM_MODE_ADDR, 8'h68, 0, 0);
		rd_chk(`WDM_MODE_ADDR, 8'h68);
		mis(`WDM_MODE_ADDR, 8'h61, 0, 1);
		rd_chk(`WDM_MODE_ADDR, 8'h67);
		mis(`WDM_MODE_ADDR, 8'h70, 0, 0);
		mis(`WDM_MODE_ADDR, 8'h68, 0, 0);
		mis(`WDM_RESTART_ADDR, rv, 0, 0);
		mis(`WDM_RESTART_ADDR, 8'hAC, 1, 0);
		@(negedge mclk) reset_n = 0;
		repeat (4) @(negedge mclk);
		reset_n = 1;
		h = 100 + ($unsigned($random(seed)) % 4000);
		mis(`WDM_MODE_ADDR, 8'h68, 0, 0);
		tov(h, ovf(8'h68) + h, 0);
		mis(`WDM_MODE_ADDR, 8'h68, 0, 0);
		tov(500, ovf(8'h68) + 500 + 200 + `WDM_PAUSE_CYC, 1);
		mis(`WDM_MODE_ADDR, 8'h60, 0, 0);
		tov(0, ovf(8'h60), 0);
		nst = 1;
		mis(`WDM_MODE_ADDR, 8'h69, 0, 0);
		rd_chk(`WDM_MODE_ADDR, 8'h61);
		tov(2000, ovf(8'h61), 1);
		conclude();
	end
	// Watchdog on a hung run
	initial begin
		#950000;
		bad_count++;
		conclude();
	end
endmodule : wdm_watchdog_bench
`default_nettype wire
